// File: core/hmdp_pkg.sv
// Constants and types for the host/processor data port and mailbox block.
// Assumes one 10 MHz clock and an 8-bit processor register port.
// Operation
// R1 - Each host data port access moves one byte at pointer plus bank address
// R2 - Every host data port read or write advances the memory pointer by one
// R3 - All four data port aliases share pointer and bank, adding no offset
// R4 - Processor interface registers answer only the processor, never the host
// R5 - Direct-access set skips arbitration; clear sends host cycles to arbiter
// R6 - Firmware sets direct-access only while the processor stays halted
// R7 - Remap shows top 96K flash at 8000h-1FFFFh; E0000h-FFFFFh always maps
// R8 - Host power-down writes set request flag, which interrupts the processor
// R9 - Processor writing one clears the host power-down request flag
// R10 - Writing one to power-down command starts cycle; self-clears when done
// R11 - Host interrupt command sets host-interrupt flag; processor one clears
// R12 - Host-interrupt flag reaches processor only while its mask bit is one
// R13 - Interrupt-to-host raises host interrupt only while wait-control is low
// R14 - Interrupt-to-host holds until host acknowledge; zero write ignored
// R15 - Power-down completion sets done flag and interrupts the processor
// R16 - Done cleared by writing one then zero; stays held until zero written
// R17 - Every processor interface register bit resets to zero
// R18 - Fifteen-bit pointer, low byte carries into high byte, survives reset
// R19 - Processor interrupt ORs request, done, and masked host-interrupt flags
package hmdp_pkg;
   localparam int PTR_W  = 15;
   localparam int BANK_W = 3;
   localparam int MADDR_W = PTR_W + BANK_W;
   localparam int DATA_W = 8;
   localparam int CADDR_W = 4;
   localparam int FOFS_W = 17;
   localparam int CPU_AW = 20;
   localparam int BUF_DEPTH = 2;

   localparam logic [CADDR_W-1:0] PIR_OFFSET = 4'h0;
   localparam logic [DATA_W-1:0]  PIR_RESET  = 8'h00;

   localparam int B_DIRECT = 7;
   localparam int B_REMAP  = 6;
   localparam int B_PDREQ  = 5;
   localparam int B_PDCMD  = 4;
   localparam int B_HINT   = 3;
   localparam int B_TOHOST = 2;
   localparam int B_HMASK  = 1;
   localparam int B_PDDONE = 0;

   localparam logic [CPU_AW-1:0] REMAP_LO   = 20'h08000;
   localparam logic [CPU_AW-1:0] REMAP_HI   = 20'h1ffff;
   localparam logic [CPU_AW-1:0] FLASH_BASE = 20'he0000;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ARB   = 3'b010,
      ST_ISSUE = 3'b100
   } hmdp_state_t;
endpackage

// File: core/hmdp_stream_if.sv
// Byte stream carrier with valid/ready between the block's own modules.
// Assumes both ends share the block clock.
`timescale 1ns/100ps
interface hmdp_stream_if;
   logic [7:0] data;
   logic       valid;
   logic       ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// File: core/hmdp_buf.sv
// Two-entry read data buffer between memory and host.
// Assumes source honours ready; sink may stall freely.
`timescale 1ns/100ps
module hmdp_buf (
   input wire logic    clock,
   input wire logic    rstn,
   hmdp_stream_if.snk  inS,
   hmdp_stream_if.src  outS
);
   logic [7:0] mem_r [hmdp_pkg::BUF_DEPTH];
   logic       wrIdx_r;
   logic       rdIdx_r;
   logic [1:0] count_r;
   logic [1:0] count_nxt;
   wire        push = inS.valid && inS.ready;
   wire        pop  = outS.valid && outS.ready;

   assign inS.ready  = (count_r != 2'h2);
   assign outS.valid = (count_r != 2'h0);
   assign outS.data  = mem_r[rdIdx_r];
   assign count_nxt  = count_r + {1'b0, push} - {1'b0, pop};

   genvar i;
   generate
      for (i = 0; i < hmdp_pkg::BUF_DEPTH; i++) begin : g_ent
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) mem_r[i] <= 8'h00;
            else if (push && wrIdx_r == 1'(i)) mem_r[i] <= inS.data;
         end
      end
   endgenerate

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wrIdx_r <= 1'b0;
         rdIdx_r <= 1'b0;
         count_r <= 2'h0;
      end else begin
         wrIdx_r <= wrIdx_r ^ push;
         rdIdx_r <= rdIdx_r ^ pop;
         count_r <= count_nxt;
      end
   end
endmodule // hmdp_buf

// File: core/hmdp_ptr.sv
// Fifteen-bit local memory pointer with byte loads and increment.
// Assumes loads and increments never coincide; a load wins if they do.
`timescale 1ns/100ps
module hmdp_ptr (
   input  wire logic        clock,
   input  wire logic        loLoad,
   input  wire logic        hiLoad,
   input  wire logic [7:0]  loadData,
   input  wire logic        inc,
   output logic      [14:0] ptr
);
   // No reset on purpose: software expects the pointer to survive reset
   always_ff @(posedge clock) begin // R18
      if (loLoad) ptr[7:0] <= loadData;
      else if (hiLoad) ptr[14:8] <= loadData[6:0];
      else if (inc) ptr <= ptr + 15'h0001; // R2 R18
   end
endmodule // hmdp_ptr

// File: core/hmdp_mailbox.sv
// Host data ports, processor interface register and flash remap decode.
// Assumes a memory arbiter grants cycles and a power-down sequencer
// reports completion with a one-cycle pulse.
`timescale 1ns/100ps
module hmdp_mailbox (
   input  wire logic        clock,
   input  wire logic        rstn,
   // Host data port side
   input  wire logic        hostRdStb,
   input  wire logic        hostWrStb,
   input  wire logic [7:0]  hostWrData,
   input  wire logic [2:0]  hostBankSel,
   input  wire logic        hostPtrLoWr,
   input  wire logic        hostPtrHiWr,
   output logic             hostReady,
   output logic      [7:0]  hostRdData,
   output logic             hostRdValid,
   input  wire logic        hostRdReady,
   // Host mailbox events
   input  wire logic        hostPdReqWr,
   input  wire logic        isaPowerdownWr,
   input  wire logic        hostToCpuIrqCmd,
   input  wire logic        hostIrqAck,
   input  wire logic        hostWaitControl,
   output logic             hostIrq,
   // Processor register side
   input  wire logic [3:0]  cpuAddr,
   input  wire logic        cpuWrStb,
   input  wire logic        cpuRdStb,
   input  wire logic [7:0]  cpuWrData,
   output logic      [7:0]  cpuRdData,
   output logic             cpuIrq,
   // Processor flash decode
   input  wire logic [19:0] cpuMemAddr,
   output logic             flashHit,
   output logic      [16:0] flashOffset,
   // Power-down sequencer
   output logic             powerdownStart,
   input  wire logic        powerdownComplete,
   // Mode outputs
   output logic             directAccessMode,
   output logic             flashRemapEnable,
   // Local memory
   output logic      [17:0] memAddr,
   output logic             memReq,
   output logic             memWe,
   output logic      [7:0]  memWrData,
   input  wire logic        memGrant,
   input  wire logic        memAck,
   input  wire logic [7:0]  memRdData
);

   // ==========================================================
   // Declarations
   // ==========================================================
   hmdp_pkg::hmdp_state_t state_r;
   hmdp_pkg::hmdp_state_t state_nxt;
   logic [14:0] ptr;
   logic [17:0] addr_r;
   logic        we_r;
   logic [7:0]  wdata_r;

   logic        direct_r;
   logic        remap_r;
   logic        pdReq_r;
   logic        pdCmd_r;
   logic        hostInt_r;
   logic        toHost_r;
   logic        hostMask_r;
   logic        pdDone_r;
   logic        pdHeld_r;
   logic [7:0]  cpuRdData_r;

   logic        direct_nxt;
   logic        remap_nxt;
   logic        pdReq_nxt;
   logic        pdCmd_nxt;
   logic        hostInt_nxt;
   logic        toHost_nxt;
   logic        hostMask_nxt;
   logic        pdDone_nxt;
   logic        pdHeld_nxt;

   hmdp_stream_if rdIn ();
   hmdp_stream_if rdOut ();

   // ==========================================================
   // Host data port accept
   // ==========================================================
   // Reads are taken only when the buffer has room, so a stalled
   // host pushes back on the data port instead of losing a byte.
   wire hostReq  = hostRdStb || hostWrStb;
   wire isIdle   = (state_r == hmdp_pkg::ST_IDLE);
   wire accept   = hostReq && hostReady;
   wire issueEnd = (state_r == hmdp_pkg::ST_ISSUE) && memAck;

   assign hostReady = isIdle && rdIn.ready;

   // The port alias never enters the address: one pointer serves all
   wire [17:0] portAddr = {hostBankSel, ptr}; // R1 R3

   hmdp_ptr u_ptr (
      .clock    (clock),
      .loLoad   (hostPtrLoWr),
      .hiLoad   (hostPtrHiWr),
      .loadData (hostWrData),
      .inc      (accept),
      .ptr      (ptr)
   );

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         addr_r  <= 18'h00000;
         we_r    <= 1'b0;
         wdata_r <= 8'h00;
      end else if (accept) begin
         addr_r  <= portAddr; // R1
         we_r    <= hostWrStb;
         wdata_r <= hostWrData;
      end
   end

   // ==========================================================
   // Memory cycle sequencer
   // ==========================================================
   // Direct mode skips the grant wait; firmware keeps the processor
   // halted then, so no other master can collide with the host.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         hmdp_pkg::ST_IDLE: begin
            if (accept && direct_r) state_nxt = hmdp_pkg::ST_ISSUE; // R5 R6
            else if (accept) state_nxt = hmdp_pkg::ST_ARB; // R5
         end
         hmdp_pkg::ST_ARB: begin
            if (memGrant) state_nxt = hmdp_pkg::ST_ISSUE;
         end
         hmdp_pkg::ST_ISSUE: begin
            if (memAck) state_nxt = hmdp_pkg::ST_IDLE;
         end
         default: state_nxt = hmdp_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) state_r <= hmdp_pkg::ST_IDLE;
      else state_r <= state_nxt;
   end

   assign memReq    = (state_r == hmdp_pkg::ST_ISSUE);
   assign memAddr   = addr_r;
   assign memWe     = we_r;
   assign memWrData = wdata_r;

   // ==========================================================
   // Read data buffer
   // ==========================================================
   assign rdIn.data   = memRdData;
   assign rdIn.valid  = issueEnd && !we_r; // R1
   assign rdOut.ready = hostRdReady;
   assign hostRdData  = rdOut.data;
   assign hostRdValid = rdOut.valid;

   hmdp_buf u_buf (
      .clock (clock),
      .rstn  (rstn),
      .inS   (rdIn),
      .outS  (rdOut)
   );

   // ==========================================================
   // Processor interface register
   // ==========================================================
   // Only the processor port decodes this register; host strobes
   // appear below solely as set and clear events.
   wire pirWr = cpuWrStb && (cpuAddr == hmdp_pkg::PIR_OFFSET); // R4
   wire pirRd = cpuRdStb && (cpuAddr == hmdp_pkg::PIR_OFFSET); // R4
   wire [7:0] w1 = pirWr ? cpuWrData : 8'h00;
   wire hostPdEvt = hostPdReqWr || isaPowerdownWr;

   assign direct_nxt = pirWr ? cpuWrData[hmdp_pkg::B_DIRECT]
                             : direct_r; // R5
   assign remap_nxt  = pirWr ? cpuWrData[hmdp_pkg::B_REMAP]
                             : remap_r; // R7
   assign hostMask_nxt = pirWr ? cpuWrData[hmdp_pkg::B_HMASK]
                               : hostMask_r; // R12
   // Hardware sets win over a same-cycle processor clear
   assign pdReq_nxt = hostPdEvt ||
                      (pdReq_r && !w1[hmdp_pkg::B_PDREQ]); // R8 R9
   assign pdCmd_nxt = w1[hmdp_pkg::B_PDCMD] ||
                      (pdCmd_r && !powerdownComplete); // R10
   assign hostInt_nxt = hostToCpuIrqCmd ||
                        (hostInt_r && !w1[hmdp_pkg::B_HINT]); // R11
   // A zero write leaves it alone; only the host acknowledge clears
   assign toHost_nxt = w1[hmdp_pkg::B_TOHOST] ||
                       (toHost_r && !hostIrqAck); // R14
   // Writing one parks the flag in reset until a zero is written
   assign pdHeld_nxt = w1[hmdp_pkg::B_PDDONE] ? 1'b1 :
                       pirWr ? 1'b0 : pdHeld_r; // R16
   assign pdDone_nxt = !pdHeld_nxt &&
                       (powerdownComplete || pdDone_r); // R15 R16

   assign powerdownStart = w1[hmdp_pkg::B_PDCMD] && !pdCmd_r; // R10

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin // R17
         direct_r   <= hmdp_pkg::PIR_RESET[hmdp_pkg::B_DIRECT];
         remap_r    <= hmdp_pkg::PIR_RESET[hmdp_pkg::B_REMAP];
         pdReq_r    <= hmdp_pkg::PIR_RESET[hmdp_pkg::B_PDREQ];
         pdCmd_r    <= hmdp_pkg::PIR_RESET[hmdp_pkg::B_PDCMD];
         hostInt_r  <= hmdp_pkg::PIR_RESET[hmdp_pkg::B_HINT];
         toHost_r   <= hmdp_pkg::PIR_RESET[hmdp_pkg::B_TOHOST];
         hostMask_r <= hmdp_pkg::PIR_RESET[hmdp_pkg::B_HMASK];
         pdDone_r   <= hmdp_pkg::PIR_RESET[hmdp_pkg::B_PDDONE];
         pdHeld_r   <= 1'b0;
      end else begin
         direct_r   <= direct_nxt;
         remap_r    <= remap_nxt;
         pdReq_r    <= pdReq_nxt;
         pdCmd_r    <= pdCmd_nxt;
         hostInt_r  <= hostInt_nxt;
         toHost_r   <= toHost_nxt;
         hostMask_r <= hostMask_nxt;
         pdDone_r   <= pdDone_nxt;
         pdHeld_r   <= pdHeld_nxt;
      end
   end

   wire [7:0] pirValue = {direct_r, remap_r, pdReq_r, pdCmd_r,
                          hostInt_r, toHost_r, hostMask_r, pdDone_r};

   // Other processor-side registers live outside; they read as zero here
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) cpuRdData_r <= 8'h00;
      else if (cpuRdStb) cpuRdData_r <= pirRd ? pirValue : 8'h00;
   end
   assign cpuRdData = cpuRdData_r;

   // ==========================================================
   // Interrupts and mode outputs
   // ==========================================================
   assign cpuIrq = pdReq_r || pdDone_r ||
                   (hostInt_r && hostMask_r); // R8 R12 R15 R19
   assign hostIrq = toHost_r && !hostWaitControl; // R13
   assign directAccessMode = direct_r;
   assign flashRemapEnable = remap_r;

   // ==========================================================
   // Flash decode
   // ==========================================================
   // Flash is 128K, so both windows use the low address bits as offset
   wire inNormal = (cpuMemAddr >= hmdp_pkg::FLASH_BASE); // R7
   wire inRemap  = remap_r && (cpuMemAddr >= hmdp_pkg::REMAP_LO) &&
                   (cpuMemAddr <= hmdp_pkg::REMAP_HI); // R7
   assign flashHit    = inNormal || inRemap;
   assign flashOffset = cpuMemAddr[16:0];

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence S_PD_W1;
      pirWr && cpuWrData[hmdp_pkg::B_PDDONE];
   endsequence
   sequence S_PD_QUIET;
      !pirWr && !powerdownComplete;
   endsequence
   sequence S_CMD_SET;
      pirWr && cpuWrData[hmdp_pkg::B_PDCMD] && !pdCmd_r;
   endsequence

   AST_ADDR: assert property ( // R1
      accept |=> addr_r == {$past(hostBankSel), $past(ptr)})
      else $error("data port address not pointer plus bank");
   AST_PTR_INC: assert property ( // R2
      accept && !hostPtrLoWr && !hostPtrHiWr |=>
      ptr == $past(ptr) + 15'h0001)
      else $error("pointer did not advance by one");
   AST_NO_OFS: assert property ( // R3
      accept |=> memAddr[14:0] == $past(ptr))
      else $error("data port added an offset");
   AST_HOST_ISOL: assert property ( // R4
      !cpuWrStb |=> pirValue[7:6] == $past(pirValue[7:6]))
      else $error("register changed without processor write");
   AST_DIRECT: assert property ( // R5
      accept && direct_r |=> memReq)
      else $error("direct cycle did not issue at once");
   AST_ARBIT: assert property ( // R5
      accept && !direct_r |=> !memReq ##1 memReq == $past(memGrant))
      else $error("arbitrated cycle skipped grant wait");
   AST_REMAP: assert property ( // R7
      remap_r && cpuMemAddr >= hmdp_pkg::REMAP_LO &&
      cpuMemAddr <= hmdp_pkg::REMAP_HI |-> flashHit)
      else $error("remap window missed");
   AST_PDREQ: assert property ( // R8
      hostPdEvt |=> pdReq_r && cpuIrq)
      else $error("host power-down request not flagged");
   AST_PDREQ_CLR: assert property ( // R9
      w1[hmdp_pkg::B_PDREQ] && !hostPdEvt |=> !pdReq_r)
      else $error("request flag not cleared");
   AST_PDCMD: assert property ( // R10
      S_CMD_SET |-> powerdownStart ##1 pdCmd_r)
      else $error("power-down command did not start");
   AST_PDCMD_END: assert property ( // R10
      pdCmd_r && powerdownComplete && !w1[hmdp_pkg::B_PDCMD] |=> !pdCmd_r)
      else $error("power-down command did not self clear");
   AST_HINT: assert property ( // R11
      hostToCpuIrqCmd |=> hostInt_r)
      else $error("host interrupt flag not set");
   AST_MASK: assert property ( // R12
      !hostMask_r && !pdReq_r && !pdDone_r |-> !cpuIrq)
      else $error("masked host interrupt reached processor");
   AST_TOHOST: assert property ( // R13
      hostIrq |-> toHost_r && !hostWaitControl)
      else $error("host interrupt without cause");
   AST_HOLD: assert property ( // R14
      toHost_r && !hostIrqAck |=> toHost_r)
      else $error("interrupt-to-host dropped early");
   AST_DONE: assert property ( // R15
      powerdownComplete && !pdHeld_nxt |=> pdDone_r && cpuIrq)
      else $error("done flag not set");
   AST_DONE_HELD: assert property ( // R16
      S_PD_W1 ##1 S_PD_QUIET[*2] |-> !pdDone_r && pdHeld_r)
      else $error("done flag not held after one written");
endmodule // hmdp_mailbox

// File: test/hmdp_mem_model.sv
// Local memory and arbiter partner for the data port block.
// Assumes one shared clock; memAck is a one-cycle pulse with read data.
`timescale 1ns/100ps
module hmdp_mem_model (
   input  wire logic        clock,
   input  wire logic        slow,
   input  wire logic [17:0] memAddr,
   input  wire logic        memReq,
   input  wire logic        memWe,
   input  wire logic [7:0]  memWrData,
   output logic             memGrant,
   output logic             memAck,
   output logic      [7:0]  memRdData
);
   logic [7:0] mem [logic [17:0]];
   logic [1:0] waitCnt;

   initial begin
      memGrant  = 1'b0;
      memAck    = 1'b0;
      memRdData = 8'h00;
      waitCnt   = 2'h0;
   end

   // ==========================================================
   // Grant and acknowledge
   // Slow mode withholds grant every other cycle and stretches
   // the access, so arbitration waits are really exercised.
   always @(posedge clock) begin
      memGrant <= slow ? ~memGrant : 1'b1;
      if (memReq && !memAck && waitCnt == (slow ? 2'h2 : 2'h0)) begin
         memAck  <= 1'b1;
         waitCnt <= 2'h0;
         if (memWe)
            mem[memAddr] = memWrData;
         memRdData <= mem.exists(memAddr) ? mem[memAddr] : ~memAddr[7:0];
      end else begin
         memAck <= 1'b0;
         // Data bus is stale outside an acknowledge: keep it moving
         memRdData <= ~memRdData;
         if (memReq && !memAck)
            waitCnt <= waitCnt + 2'h1;
      end
   end
endmodule // hmdp_mem_model

// File: test/test_hmdp_mailbox.sv
// Self-checking bench for the host data port and mailbox block.
// Assumes the design files and the memory partner model are compiled first.
`timescale 1ns/100ps
module test_hmdp_mailbox;
   logic        clock, rstn, slow, hostRdStb, hostWrStb, hostReady;
   logic        hostPtrLoWr, hostPtrHiWr, hostRdValid, hostRdReady;
   logic        hostWaitControl, hostIrq, cpuWrStb, cpuRdStb, cpuIrq;
   logic        flashHit, powerdownStart, directAccessMode;
   logic        flashRemapEnable, memReq, memWe, memGrant, memAck;
   logic [4:0]  evt;
   logic [3:0]  cpuAddr;
   logic [7:0]  hostWrData, hostRdData, cpuWrData, cpuRdData;
   logic [7:0]  memWrData, memRdData;
   logic [17:0] memAddr;
   logic [19:0] cpuMemAddr;
   logic [16:0] flashOffset;
   int          bad_count = 0;
   int          checked = 0;
   int          pdStarts = 0;
   logic [19:0] fa [4] = '{20'h08000, 20'h1ffff, 20'h20000, 20'he0000};
   logic        fh [4] = '{1'b1, 1'b1, 1'b0, 1'b1};

   hmdp_mailbox dut (
      .clock(clock), .rstn(rstn), .hostRdStb(hostRdStb),
      .hostWrStb(hostWrStb), .hostWrData(hostWrData),
      .hostBankSel(3'h5), .hostPtrLoWr(hostPtrLoWr),
      .hostPtrHiWr(hostPtrHiWr), .hostReady(hostReady),
      .hostRdData(hostRdData), .hostRdValid(hostRdValid),
      .hostRdReady(hostRdReady), .hostPdReqWr(evt[4]),
      .isaPowerdownWr(evt[3]), .hostToCpuIrqCmd(evt[2]),
      .hostIrqAck(evt[1]), .hostWaitControl(hostWaitControl),
      .hostIrq(hostIrq), .cpuAddr(cpuAddr), .cpuWrStb(cpuWrStb),
      .cpuRdStb(cpuRdStb), .cpuWrData(cpuWrData), .cpuRdData(cpuRdData),
      .cpuIrq(cpuIrq), .cpuMemAddr(cpuMemAddr), .flashHit(flashHit),
      .flashOffset(flashOffset), .powerdownStart(powerdownStart),
      .powerdownComplete(evt[0]), .directAccessMode(directAccessMode),
      .flashRemapEnable(flashRemapEnable), .memAddr(memAddr),
      .memReq(memReq), .memWe(memWe), .memWrData(memWrData),
      .memGrant(memGrant), .memAck(memAck), .memRdData(memRdData));

   hmdp_mem_model pm (
      .clock(clock), .slow(slow), .memAddr(memAddr), .memReq(memReq),
      .memWe(memWe), .memWrData(memWrData), .memGrant(memGrant),
      .memAck(memAck), .memRdData(memRdData));

   // ==========================================================
   // Clock, watchdog and monitors
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   initial begin
      repeat (5000) @(posedge clock);
      bad_count++;
      give_verdict;
   end
   always @(negedge clock) if (powerdownStart === 1'b1) pdStarts++;

   // ==========================================================
   // Access tasks
   task automatic chk(input string what, input logic [16:0] got,
                      input logic [16:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic cpuWr(input logic [7:0] d);
      @(posedge clock);
      cpuAddr   <= 4'h0;
      cpuWrData <= d;
      cpuWrStb  <= 1'b1;
      @(posedge clock);
      cpuWrStb  <= 1'b0;
      #1;
   endtask
   task automatic cpuRd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock);
      cpuAddr  <= a;
      cpuRdStb <= 1'b1;
      @(posedge clock);
      cpuRdStb <= 1'b0;
      #1 chk("cpuRdData", cpuRdData, e);
   endtask
   // Strobe is held until an edge that sees hostReady high
   task automatic hostAcc(input logic we, input logic [7:0] d);
      int n;
      @(posedge clock);
      hostWrStb  <= we;
      hostRdStb  <= !we;
      hostWrData <= d;
      for (n = 0; n < 40; n++) begin
         @(negedge clock);
         if (hostReady === 1'b1) break;
      end
      if (n == 40) chk("hostReady wait", 1'b0, 1'b1);
      @(posedge clock);
      hostWrStb <= 1'b0;
      hostRdStb <= 1'b0;
   endtask
   task automatic pop(input logic [7:0] e);
      int n;
      for (n = 0; n < 40; n++) begin
         @(negedge clock);
         if (hostRdValid === 1'b1) break;
      end
      chk("hostRdData", hostRdData, e);
      @(posedge clock);
      hostRdReady <= 1'b1;
      @(posedge clock);
      hostRdReady <= 1'b0;
   endtask
   task automatic ptrLoad(input logic [14:0] p);
      @(posedge clock);
      hostWrData  <= p[7:0];
      hostPtrLoWr <= 1'b1;
      @(posedge clock);
      hostPtrLoWr <= 1'b0;
      hostWrData  <= {1'b0, p[14:8]};
      hostPtrHiWr <= 1'b1;
      @(posedge clock);
      hostPtrHiWr <= 1'b0;
   endtask
   // Event bits: 4 pd request, 3 isa pd, 2 irq command, 1 ack, 0 done
   task automatic pulse(input int k);
      @(posedge clock);
      evt <= 5'h01 << k;
      @(posedge clock);
      evt <= 5'h00;
      #1;
   endtask
   task automatic flashChk(input logic r);
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         cpuMemAddr <= fa[i];
         @(negedge clock);
         chk("flashHit", flashHit, fa[i] >= 20'he0000 || (r && fh[i]));
         if (flashHit === 1'b1) chk("flashOffset", flashOffset, fa[i][16:0]);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // Test sequence
   initial begin
      {rstn, hostRdStb, hostWrStb, hostPtrLoWr, hostPtrHiWr} = 5'h00;
      {hostRdReady, hostWaitControl, cpuWrStb, cpuRdStb} = 4'h0;
      {evt, cpuAddr, cpuWrData, hostWrData} = 25'h0000000;
      cpuMemAddr = 20'h00000;
      slow = 1'b1;
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      cpuRd(4'h0, 8'h00);
      ptrLoad(15'h00fe);
      hostAcc(1'b1, 8'ha1);
      hostAcc(1'b1, 8'hb2);
      hostAcc(1'b1, 8'hc3);
      repeat (8) @(posedge clock);
      chk("mem 280fe", pm.mem[18'h280fe], 8'ha1);
      chk("mem 280ff", pm.mem[18'h280ff], 8'hb2);
      chk("mem 28100", pm.mem[18'h28100], 8'hc3);
      cpuWr(8'h42);
      chk("directAccessMode", directAccessMode, 1'b0);
      chk("flashRemapEnable", flashRemapEnable, 1'b1);
      cpuRd(4'h0, 8'h42);
      cpuRd(4'h3, 8'h00);
      flashChk(1'b1);
      // Bench acts as firmware: the processor stays halted in direct mode
      cpuWr(8'hc2);
      chk("directAccessMode", directAccessMode, 1'b1);
      slow <= 1'b0;
      ptrLoad(15'h00fe);
      hostAcc(1'b0, 8'h00);
      hostAcc(1'b0, 8'h00);
      repeat (8) @(posedge clock);
      @(negedge clock);
      chk("hostReady full", hostReady, 1'b0);
      pop(8'ha1);
      pop(8'hb2);
      hostAcc(1'b0, 8'h00);
      pop(8'hc3);
      cpuWr(8'h02);
      flashChk(1'b0);
      pulse(2);
      chk("cpuIrq", cpuIrq, 1'b1);
      cpuRd(4'h0, 8'h0a);
      cpuWr(8'h00);
      chk("cpuIrq", cpuIrq, 1'b0);
      cpuWr(8'h08);
      cpuRd(4'h0, 8'h00);
      pulse(4);
      chk("cpuIrq", cpuIrq, 1'b1);
      cpuWr(8'h20);
      cpuRd(4'h0, 8'h00);
      chk("cpuIrq", cpuIrq, 1'b0);
      pulse(3);
      cpuRd(4'h0, 8'h20);
      cpuWr(8'h24);
      chk("hostIrq", hostIrq, 1'b1);
      @(posedge clock);
      hostWaitControl <= 1'b1;
      #1 chk("hostIrq", hostIrq, 1'b0);
      @(posedge clock);
      hostWaitControl <= 1'b0;
      cpuWr(8'h00);
      cpuRd(4'h0, 8'h04);
      pulse(1);
      cpuRd(4'h0, 8'h00);
      chk("hostIrq", hostIrq, 1'b0);
      cpuWr(8'h10);
      cpuWr(8'h10);
      chk("powerdownStart count", pdStarts[16:0], 17'h00001);
      cpuRd(4'h0, 8'h10);
      pulse(0);
      cpuRd(4'h0, 8'h01);
      chk("cpuIrq", cpuIrq, 1'b1);
      // Clear takes a one then a zero; done stays held in between
      cpuWr(8'h01);
      cpuRd(4'h0, 8'h00);
      pulse(0);
      cpuRd(4'h0, 8'h00);
      cpuWr(8'h00);
      pulse(0);
      cpuRd(4'h0, 8'h01);
      // Mid-run reset clears the register but must leave the pointer alone
      @(posedge clock);
      rstn <= 1'b0;
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      cpuRd(4'h0, 8'h00);
      hostAcc(1'b1, 8'h5a);
      repeat (4) @(posedge clock);
      chk("mem 28101", pm.mem[18'h28101], 8'h5a);
      give_verdict;
   end
endmodule // test_hmdp_mailbox
